// ==== verilog/frsc_cfg.svh ====
// Constants and register map of the flash reset and unsecure controller
`ifndef FRSC_CFG_SVH
`define FRSC_CFG_SVH
`define FRSC_ADDR_W 4
`define FRSC_OFS_STATUS 4'h0
`define FRSC_OFS_CMDIDX 4'h1
`define FRSC_OFS_CCOBHI 4'h2
`define FRSC_OFS_CCOBLO 4'h3
`define FRSC_OFS_PPROT 4'h4
`define FRSC_OFS_DPROT 4'h5
`define FRSC_OFS_OPTION 4'h6
`define FRSC_OFS_SECURE 4'h7
`define FRSC_OFS_IRQST 4'h8
`define FRSC_OFS_IRQMSK 4'h9
`define FRSC_OFS_MODE 4'hA
`define FRSC_OFS_LAUNCH 4'hB
`define FRSC_SEC_ADDR 18'h3FF0F
`define FRSC_CFG_ADDR 18'h3FF08
`define FRSC_SEC_UNSEC 2'h2
`define FRSC_SEC_DEFAULT 8'hFF
`define FRSC_PROT_DEFAULT 8'h00
`define FRSC_OPT_DEFAULT 8'hFF
`define FRSC_CFG_DEFAULT 8'h00
`define FRSC_ST_COMMAND_COMPLETE_FLAG 7
`define FRSC_ST_MG1 1
`define FRSC_ST_MG0 0
`define FRSC_ST_ACCERR 5
`define FRSC_CMD_ERASE_VFY_ALL 8'h01
`define FRSC_CMD_PROGRAM 8'h06
`define FRSC_CMD_ERASE_ALL 8'h08
`define FRSC_CMD_BACKDOOR 8'h0C
`define FRSC_STALL_CYC 4
`endif

// ==== verilog/frsc_pkg.sv ====
// Types shared by the flash reset and unsecure controller
`default_nettype none
package frsc_pkg;
    typedef enum logic [3:0] {
        FRSC_S_STALL = 4'h0,
        FRSC_S_LD_CFG = 4'h1,
        FRSC_S_LD_PPROT = 4'h2,
        FRSC_S_LD_DPROT = 4'h3,
        FRSC_S_LD_OPT = 4'h4,
        FRSC_S_LD_SEC = 4'h5,
        FRSC_S_VERIFY = 4'h6,
        FRSC_S_IDLE = 4'h7,
        FRSC_S_EXEC = 4'h8
    } frsc_state_t;
endpackage : frsc_pkg
`default_nettype wire

// ==== verilog/frsc_array_port.sv ====
// Array read/command port sequencer: one request, waits for the array answer
`timescale 1ns/1ns
`default_nettype none
module frsc_array_port (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_start,
    input wire logic i_is_cmd,
    input wire logic [17:0] i_addr,
    input wire logic [7:0] i_cmd,
    output logic o_req,
    output logic o_cmd_req,
    output logic [17:0] o_addr,
    output logic [7:0] o_cmd,
    input wire logic i_ack,
    input wire logic [7:0] i_rdata,
    input wire logic i_ecc_dbl,
    input wire logic i_err,
    output logic o_done,
    output logic [7:0] o_data,
    output logic o_dbl,
    output logic o_bad
);
    typedef struct packed {
        logic busy;
        logic req;
        logic cmd_req;
        logic [17:0] addr;
        logic [7:0] cmd;
        logic done;
        logic [7:0] data;
        logic dbl;
        logic bad;
    } frsc_port_st_t;
    frsc_port_st_t s_q, s_d;

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (!s_q.busy && i_start) begin
            s_d.busy = 1'b1;
            s_d.req = !i_is_cmd;
            s_d.cmd_req = i_is_cmd;
            s_d.addr = i_addr;
            s_d.cmd = i_cmd;
        end else if (s_q.busy && i_ack) begin
            s_d.busy = 1'b0;
            s_d.req = 1'b0;
            s_d.cmd_req = 1'b0;
            s_d.done = 1'b1;
            s_d.data = i_rdata;
            s_d.dbl = i_ecc_dbl;
            s_d.bad = i_err | i_ecc_dbl;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_req = s_q.req;
    assign o_cmd_req = s_q.cmd_req;
    assign o_addr = s_q.addr;
    assign o_cmd = s_q.cmd;
    assign o_done = s_q.done;
    assign o_data = s_q.data;
    assign o_dbl = s_q.dbl;
    assign o_bad = s_q.bad;
endmodule : frsc_array_port
`default_nettype wire

// ==== verilog/frsc_top.sv ====
// Flash reset-time loader, command gate and security recovery controller
//
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "frsc_cfg.svh"
module frsc_top (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_special_mode,
    input wire logic [`FRSC_ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    output logic o_cpu_stall,
    output logic o_irq,
    output logic o_debug_full,
    output logic o_arr_req,
    output logic o_arr_cmd_req,
    output logic [17:0] o_arr_addr,
    output logic [7:0] o_arr_cmd,
    input wire logic i_arr_ack,
    input wire logic [7:0] i_arr_rdata,
    input wire logic i_arr_ecc_dbl,
    input wire logic i_arr_err,
    input wire logic i_arr_blank
);
    typedef struct packed {
        frsc_pkg::frsc_state_t st;
        logic [2:0] stall_cnt;
        logic start;
        logic is_cmd;
        logic [17:0] addr;
        logic [7:0] cmd;
        logic load_err;
        logic stall;
        logic command_complete_flag;
        logic mg1;
        logic mg0;
        logic accerr;
        logic [7:0] blkcfg;
        logic [7:0] pprot;
        logic [7:0] dprot;
        logic [7:0] option;
        logic [7:0] secure;
        logic [2:0] cmdidx;
        logic [7:0] ccobhi;
        logic [7:0] ccoblo;
        logic [1:0] irq_st;
        logic [1:0] irq_msk;
        logic debug_full;
        logic backdoor_lock;
        logic [7:0] rdata;
        logic irq;
    } frsc_st_t;
    frsc_st_t s_q, s_d;

    logic port_done;
    logic [7:0] port_data;
    logic port_dbl;
    logic port_bad;

    // =====================================================
    // Array access sequencer
    frsc_array_port u_port (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_start(s_q.start),
        .i_is_cmd(s_q.is_cmd),
        .i_addr(s_q.addr),
        .i_cmd(s_q.cmd),
        .o_req(o_arr_req),
        .o_cmd_req(o_arr_cmd_req),
        .o_addr(o_arr_addr),
        .o_cmd(o_arr_cmd),
        .i_ack(i_arr_ack),
        .i_rdata(i_arr_rdata),
        .i_ecc_dbl(i_arr_ecc_dbl),
        .i_err(i_arr_err),
        .o_done(port_done),
        .o_data(port_data),
        .o_dbl(port_dbl),
        .o_bad(port_bad)
    );

    function automatic logic secured(input logic [7:0] sec);
        secured = (sec[1:0] != `FRSC_SEC_UNSEC);
    endfunction : secured

    // Command availability by mode and security
    function automatic logic cmd_allowed(input logic [7:0] cmd, input logic spec,
                                         input logic sec, input logic bdlock);
        if (!sec) begin
            cmd_allowed = 1'b1;
        end else if (cmd == `FRSC_CMD_BACKDOOR) begin
            cmd_allowed = !bdlock;
        end else if (spec) begin
            cmd_allowed = (cmd == `FRSC_CMD_ERASE_VFY_ALL) || (cmd == `FRSC_CMD_ERASE_ALL);
        end else begin
            cmd_allowed = (cmd == `FRSC_CMD_ERASE_VFY_ALL);
        end
    endfunction : cmd_allowed

    // =====================================================
    // Reset sequence, bus slave and command launch
    always_comb begin
        logic [7:0] st_byte;
        logic [1:0] ev;
        st_byte = '0;
        ev = '0;
        s_d = s_q;
        s_d.start = 1'b0;
        case (s_q.st)
            frsc_pkg::FRSC_S_STALL: begin
                s_d.stall_cnt = s_q.stall_cnt + 3'h1;
                if (s_q.stall_cnt == 3'(`FRSC_STALL_CYC - 1)) begin
                    s_d.st = frsc_pkg::FRSC_S_LD_CFG;
                    s_d.start = 1'b1;
                    s_d.is_cmd = 1'b0;
                    s_d.addr = `FRSC_CFG_ADDR;
                end
            end
            frsc_pkg::FRSC_S_LD_CFG, frsc_pkg::FRSC_S_LD_PPROT, frsc_pkg::FRSC_S_LD_DPROT,
            frsc_pkg::FRSC_S_LD_OPT, frsc_pkg::FRSC_S_LD_SEC: begin
                if (port_done) begin
                    if (port_dbl) begin
                        s_d.mg1 = 1'b1;
                        s_d.mg0 = 1'b1;
                    end
                    s_d.load_err = s_q.load_err | port_bad;
                    s_d.start = 1'b1;
                    s_d.addr = s_q.addr + 18'h1;
                    case (s_q.st)
                        frsc_pkg::FRSC_S_LD_CFG: begin
                            s_d.blkcfg = port_data;
                            s_d.st = frsc_pkg::FRSC_S_LD_PPROT;
                        end
                        frsc_pkg::FRSC_S_LD_PPROT: begin
                            s_d.pprot = port_data;
                            s_d.st = frsc_pkg::FRSC_S_LD_DPROT;
                        end
                        frsc_pkg::FRSC_S_LD_DPROT: begin
                            s_d.dprot = port_data;
                            s_d.st = frsc_pkg::FRSC_S_LD_OPT;
                        end
                        frsc_pkg::FRSC_S_LD_OPT: begin
                            s_d.option = port_data;
                            s_d.st = frsc_pkg::FRSC_S_LD_SEC;
                            s_d.addr = `FRSC_SEC_ADDR;
                        end
                        default: begin
                            s_d.secure = port_data;
                            s_d.start = 1'b0;
                            s_d.stall = 1'b0;
                            if (s_q.load_err || port_bad) begin
                                s_d.blkcfg = `FRSC_CFG_DEFAULT;
                                s_d.pprot = `FRSC_PROT_DEFAULT;
                                s_d.dprot = `FRSC_PROT_DEFAULT;
                                s_d.option = `FRSC_OPT_DEFAULT;
                                s_d.secure = `FRSC_SEC_DEFAULT;
                            end
                            if (i_special_mode) begin
                                s_d.st = frsc_pkg::FRSC_S_VERIFY;
                                s_d.start = 1'b1;
                                s_d.is_cmd = 1'b1;
                                s_d.cmd = `FRSC_CMD_ERASE_VFY_ALL;
                            end else begin
                                s_d.st = frsc_pkg::FRSC_S_IDLE;
                                s_d.command_complete_flag = 1'b1;
                                ev[0] = 1'b1;
                            end
                        end
                    endcase
                end
            end
            frsc_pkg::FRSC_S_VERIFY: begin
                if (port_done) begin
                    s_d.st = frsc_pkg::FRSC_S_IDLE;
                    s_d.command_complete_flag = 1'b1;
                    ev[0] = 1'b1;
                    if (!port_bad && i_arr_blank) begin
                        s_d.secure = {s_q.secure[7:2], `FRSC_SEC_UNSEC};
                        s_d.debug_full = 1'b1;
                    end else begin
                        s_d.mg1 = port_bad;
                        s_d.mg0 = port_dbl;
                    end
                end
            end
            frsc_pkg::FRSC_S_EXEC: begin
                if (port_done) begin
                    s_d.st = frsc_pkg::FRSC_S_IDLE;
                    s_d.command_complete_flag = 1'b1;
                    ev[0] = 1'b1;
                    s_d.mg1 = port_bad;
                    s_d.mg0 = port_dbl;
                    if (port_dbl) begin
                        ev[1] = 1'b1;
                    end
                    if (s_q.cmd == `FRSC_CMD_BACKDOOR) begin
                        if (port_bad) begin
                            s_d.backdoor_lock = 1'b1;
                        end else begin
                            s_d.secure = {s_q.secure[7:2], `FRSC_SEC_UNSEC};
                        end
                    end else if (s_q.cmd == `FRSC_CMD_ERASE_VFY_ALL && !port_bad
                                 && i_arr_blank) begin
                        s_d.secure = {s_q.secure[7:2], `FRSC_SEC_UNSEC};
                    end
                end
            end
            default: begin
                s_d.st = frsc_pkg::FRSC_S_IDLE;
            end
        endcase

        // Register writes
        if (i_wr && !s_q.stall) begin
            if (i_addr == `FRSC_OFS_STATUS) begin
                if (i_wdata[`FRSC_ST_ACCERR]) begin
                    s_d.accerr = 1'b0;
                end
            end else if (i_addr == `FRSC_OFS_CMDIDX) begin
                if (s_q.command_complete_flag) begin
                    s_d.cmdidx = i_wdata[2:0];
                end
            end else if (i_addr == `FRSC_OFS_CCOBHI) begin
                if (s_q.command_complete_flag) begin
                    s_d.ccobhi = i_wdata;
                end
            end else if (i_addr == `FRSC_OFS_CCOBLO) begin
                if (s_q.command_complete_flag) begin
                    s_d.ccoblo = i_wdata;
                end
            end else if (i_addr == `FRSC_OFS_PPROT) begin
                if (s_q.command_complete_flag) begin
                    s_d.pprot = i_wdata;
                end
            end else if (i_addr == `FRSC_OFS_DPROT) begin
                if (s_q.command_complete_flag) begin
                    s_d.dprot = i_wdata;
                end
            end else if (i_addr == `FRSC_OFS_IRQST) begin
                s_d.irq_st = s_q.irq_st & ~i_wdata[1:0];
            end else if (i_addr == `FRSC_OFS_IRQMSK) begin
                s_d.irq_msk = i_wdata[1:0];
            end else if (i_addr == `FRSC_OFS_LAUNCH) begin
                if (s_q.command_complete_flag && i_wdata[0]) begin
                    if (cmd_allowed(s_q.ccobhi, i_special_mode, secured(s_q.secure),
                                    s_q.backdoor_lock)) begin
                        s_d.command_complete_flag = 1'b0;
                        s_d.st = frsc_pkg::FRSC_S_EXEC;
                        s_d.start = 1'b1;
                        s_d.is_cmd = 1'b1;
                        s_d.cmd = s_q.ccobhi;
                        s_d.addr = {s_q.ccoblo, 10'h000};
                    end else begin
                        s_d.accerr = 1'b1;
                    end
                end
            end
        end

        // Read data valid the cycle after the strobe
        s_d.rdata = 8'h00;
        if (i_rd && !s_q.stall) begin
            st_byte = '0;
            st_byte[`FRSC_ST_COMMAND_COMPLETE_FLAG] = s_q.command_complete_flag;
            st_byte[`FRSC_ST_ACCERR] = s_q.accerr;
            st_byte[`FRSC_ST_MG1] = s_q.mg1;
            st_byte[`FRSC_ST_MG0] = s_q.mg0;
            if (i_addr == `FRSC_OFS_STATUS) begin
                s_d.rdata = st_byte;
            end else if (i_addr == `FRSC_OFS_CMDIDX) begin
                s_d.rdata = {5'h00, s_q.cmdidx};
            end else if (i_addr == `FRSC_OFS_CCOBHI) begin
                s_d.rdata = s_q.ccobhi;
            end else if (i_addr == `FRSC_OFS_CCOBLO) begin
                s_d.rdata = s_q.ccoblo;
            end else if (i_addr == `FRSC_OFS_PPROT) begin
                s_d.rdata = s_q.pprot;
            end else if (i_addr == `FRSC_OFS_DPROT) begin
                s_d.rdata = s_q.dprot;
            end else if (i_addr == `FRSC_OFS_OPTION) begin
                s_d.rdata = s_q.option;
            end else if (i_addr == `FRSC_OFS_SECURE) begin
                s_d.rdata = s_q.secure;
            end else if (i_addr == `FRSC_OFS_IRQST) begin
                s_d.rdata = {6'h00, s_q.irq_st};
            end else if (i_addr == `FRSC_OFS_IRQMSK) begin
                s_d.rdata = {6'h00, s_q.irq_msk};
            end else if (i_addr == `FRSC_OFS_MODE) begin
                s_d.rdata = {5'h00, s_q.debug_full, i_special_mode, secured(s_q.secure)};
            end
        end

        // Events set after clears so a same-cycle set wins
        s_d.irq_st = s_d.irq_st | ev;
        s_d.irq = |(s_d.irq_st & s_d.irq_msk);
    end

    // Async reset aborts any running command and restarts the sequence
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_q <= '0;
            s_q.st <= frsc_pkg::FRSC_S_STALL;
            s_q.stall <= 1'b1;
            s_q.secure <= `FRSC_SEC_DEFAULT;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_rdata = s_q.rdata;
    assign o_cpu_stall = s_q.stall;
    assign o_irq = s_q.irq;
    assign o_debug_full = s_q.debug_full;

    // =====================================================
    // Checks
    a_command_complete_flag_clear_seq: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (s_q.st inside {frsc_pkg::FRSC_S_STALL, frsc_pkg::FRSC_S_LD_CFG,
                        frsc_pkg::FRSC_S_LD_SEC, frsc_pkg::FRSC_S_VERIFY}) |-> !s_q.command_complete_flag)
        else $error("command complete set during reset sequence");
    a_cmd_write_gated: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_wr && !s_q.command_complete_flag && i_addr == `FRSC_OFS_CCOBHI) |=> $stable(s_q.ccobhi))
        else $error("command object written before completion");
    a_stall_until_sec: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $fell(s_q.stall) |-> $past(s_q.st) == frsc_pkg::FRSC_S_LD_SEC)
        else $error("stall released before security load");
    a_dbl_sets_mg: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (port_done && port_dbl && s_q.st == frsc_pkg::FRSC_S_LD_OPT) |=> (s_q.mg1 && s_q.mg0))
        else $error("double fault did not set verify errors");
    a_err_default_sec: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (port_done && port_bad && s_q.st == frsc_pkg::FRSC_S_LD_SEC)
        |=> (s_q.secure == `FRSC_SEC_DEFAULT && s_q.pprot == `FRSC_PROT_DEFAULT))
        else $error("load error did not apply defaults");
    a_special_verify: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (port_done && s_q.st == frsc_pkg::FRSC_S_LD_SEC && i_special_mode)
        |=> (s_q.st == frsc_pkg::FRSC_S_VERIFY) ##1 o_arr_cmd_req)
        else $error("special mode verify not started");
    a_blank_unsecures: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (port_done && !port_bad && i_arr_blank && s_q.st == frsc_pkg::FRSC_S_VERIFY)
        |=> (s_q.secure[1:0] == `FRSC_SEC_UNSEC && o_debug_full && s_q.command_complete_flag))
        else $error("erased arrays did not unsecure");
    a_reject_cmd: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_wr && !s_q.stall && s_q.command_complete_flag && i_addr == `FRSC_OFS_LAUNCH && i_wdata[0]
         && !cmd_allowed(s_q.ccobhi, i_special_mode, secured(s_q.secure), s_q.backdoor_lock))
        |=> (s_q.accerr && s_q.command_complete_flag))
        else $error("unavailable command not rejected");
    a_stall_first: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (s_q.st == frsc_pkg::FRSC_S_STALL) |-> o_cpu_stall)
        else $error("cpu not stalled early in reset sequence");
endmodule : frsc_top
`default_nettype wire

// ==== test/frsc_array_model.sv ====
// Behavioural flash array answering the controller's requests
`timescale 1ns/1ns
`default_nettype none
module frsc_array_model (
    input wire logic i_clk,
    input wire logic i_req,
    input wire logic i_cmd_req,
    input wire logic [17:0] i_addr,
    input wire logic [3:0] i_delay,
    input wire logic [7:0] i_sec_byte,
    input wire logic i_dbl,
    output logic o_ack = 1'b0,
    output logic [7:0] o_rdata = 8'h00,
    output logic o_ecc_dbl = 1'b0
);
    int cnt = 0;
    logic [7:0] last = 8'h00;
    logic [7:0] word;
    assign word = (i_addr == 18'h3FF0F) ? i_sec_byte : i_addr[7:0];
    // Data only valid with the acknowledge pulse
    always @(posedge i_clk) begin
        o_ack <= 1'b0;
        o_ecc_dbl <= 1'b0;
        o_rdata <= ~last;
        if (!(i_req || i_cmd_req) || o_ack) begin
            cnt <= 0;
        end else if (cnt < i_delay) begin
            cnt <= cnt + 1;
        end else begin
            o_ack <= 1'b1;
            o_ecc_dbl <= i_dbl;
            last <= word;
            o_rdata <= word;
        end
    end
endmodule : frsc_array_model
`default_nettype wire

// ==== test/frsc_top_tb.sv ====
// Self-checking bench for the flash reset and unsecure controller
`timescale 1ns/1ns
`default_nettype none
module frsc_top_tb;
    logic i_clk = 0, i_rst_n = 0, sp = 0, i_wr = 0, i_rd = 0, dbl = 0, blank = 0;
    logic [3:0] i_addr = 4'h0, dly = 4'h1;
    logic [7:0] i_wdata = 8'h00, o_rdata, ardata, acmd, sec_byte = 8'hFF, rv;
    logic [17:0] aaddr;
    logic stall, irq, dfull, areq, acreq, aack, ecc, aerr = 1'b0;
    int fails = 0, total_checks = 0;
    always #5 i_clk = ~i_clk;
    frsc_top dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_special_mode(sp), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_cpu_stall(stall),
        .o_irq(irq), .o_debug_full(dfull), .o_arr_req(areq), .o_arr_cmd_req(acreq),
        .o_arr_addr(aaddr), .o_arr_cmd(acmd), .i_arr_ack(aack), .i_arr_rdata(ardata),
        .i_arr_ecc_dbl(ecc), .i_arr_err(aerr), .i_arr_blank(blank));
    frsc_array_model u_arr (.i_clk(i_clk), .i_req(areq), .i_cmd_req(acreq), .i_addr(aaddr),
        .i_delay(dly), .i_sec_byte(sec_byte), .i_dbl(dbl), .o_ack(aack), .o_rdata(ardata),
        .o_ecc_dbl(ecc));
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask : rd
    task automatic boot(input logic s, input logic [7:0] sb, input logic db, input logic bl);
        @(posedge i_clk);
        i_rst_n <= 1'b0;
        sp <= s;
        sec_byte <= sb;
        dbl <= db;
        blank <= bl;
        repeat (5) @(posedge i_clk);
        #1 chk("stall_in_reset", {7'h0, stall}, 8'h01);
        @(posedge i_clk);
        i_rst_n <= 1'b1;
        for (int i = 0; i < 200 && stall; i++) @(posedge i_clk);
        #1 chk("stall_free", {7'h0, stall}, 8'h00);
    endtask : boot
    task automatic wait_command_complete_flag;
        for (int i = 0; i < 100; i++) begin
            rd(4'h0, rv);
            if (rv[7] === 1'b1) break;
        end
        chk("command_complete_flag_set", rv & 8'h80, 8'h80);
    endtask : wait_command_complete_flag
    // ==============================
    // Scenarios
    task automatic t_load_ok;
        boot(1'b0, 8'hFF, 1'b0, 1'b0);
        wait_command_complete_flag();
        rd(4'h4, rv);
        chk("pprot", rv, 8'h09);
        rd(4'h6, rv);
        chk("option", rv, 8'h0B);
        rd(4'h7, rv);
        chk("security", rv, 8'hFF);
        rd(4'hA, rv);
        chk("mode", rv, 8'h01);
        rd(4'hF, rv);
        chk("unmapped", rv, 8'h00);
    endtask : t_load_ok
    task automatic t_load_dbl;
        boot(1'b0, 8'hFE, 1'b1, 1'b0);
        wait_command_complete_flag();
        chk("mg_bits", rv & 8'h03, 8'h03);
        rd(4'h4, rv);
        chk("pprot_dflt", rv, 8'h00);
        rd(4'h6, rv);
        chk("opt_dflt", rv, 8'hFF);
        rd(4'h7, rv);
        chk("sec_dflt", rv, 8'hFF);
    endtask : t_load_dbl
    task automatic t_special;
        dly <= 4'h9;
        boot(1'b1, 8'hFF, 1'b0, 1'b1);
        rd(4'h0, rv);
        chk("command_complete_flag_clear", rv & 8'h80, 8'h00);
        wr(4'h1, 8'h5A);
        wr(4'h2, 8'hA5);
        wait_command_complete_flag();
        rd(4'h1, rv);
        chk("idx_discard", rv, 8'h00);
        rd(4'h2, rv);
        chk("obj_discard", rv, 8'h00);
        chk("debug_full", {7'h0, dfull}, 8'h01);
        rd(4'h7, rv);
        chk("unsec_field", rv & 8'h03, 8'h02);
        rd(4'hA, rv);
        chk("mode_unsec", rv, 8'h06);
        wr(4'h1, 8'h5A);
        rd(4'h1, rv);
        // Index register keeps three bits
        chk("idx_taken", rv, 8'h02);
        dly <= 4'h1;
    endtask : t_special
    task automatic t_cmd;
        boot(1'b0, 8'hFF, 1'b0, 1'b0);
        wait_command_complete_flag();
        wr(4'h9, 8'h01);
        wr(4'h8, 8'h01);
        #1 chk("irq_idle", {7'h0, irq}, 8'h00);
        wr(4'h2, 8'h06);
        wr(4'h3, 8'h00);
        wr(4'hB, 8'h01);
        rd(4'h0, rv);
        chk("accerr", rv & 8'h20, 8'h20);
        wr(4'h0, 8'h20);
        wr(4'h2, 8'h01);
        wr(4'hB, 8'h01);
        for (int i = 0; i < 10 && !acreq; i++) @(posedge i_clk);
        #1 chk("cmd_code", acmd, 8'h01);
        wait_command_complete_flag();
        chk("irq_up", {7'h0, irq}, 8'h01);
        wr(4'h8, 8'h01);
        repeat (2) @(posedge i_clk);
        #1 chk("irq_down", {7'h0, irq}, 8'h00);
        wr(4'h2, 8'h0C);
        wr(4'hB, 8'h01);
        wait_command_complete_flag();
        rd(4'h7, rv);
        chk("backdoor", rv & 8'h03, 8'h02);
    endtask : t_cmd
    task automatic t_abort;
        dly <= 4'hF;
        wr(4'h2, 8'h01);
        wr(4'hB, 8'h01);
        for (int i = 0; i < 10 && !acreq; i++) @(posedge i_clk);
        i_rst_n <= 1'b0;
        @(posedge i_clk);
        #1 chk("abort", {7'h0, acreq}, 8'h00);
        dly <= 4'h1;
        aerr <= 1'b1;
        boot(1'b0, 8'hFF, 1'b0, 1'b0);
        wait_command_complete_flag();
        rd(4'h4, rv);
        chk("err_dflt", rv, 8'h00);
        aerr <= 1'b0;
    endtask : t_abort
    task automatic t_recover;
        boot(1'b1, 8'hFF, 1'b0, 1'b0);
        wait_command_complete_flag();
        rd(4'hA, rv);
        chk("still_secured", rv, 8'h03);
        wr(4'h4, 8'hFF);
        wr(4'h5, 8'hFF);
        rd(4'h5, rv);
        chk("dprot_clear", rv, 8'hFF);
        wr(4'h2, 8'h08);
        wr(4'hB, 8'h01);
        for (int i = 0; i < 10 && !acreq; i++) @(posedge i_clk);
        #1 chk("erase_all", acmd, 8'h08);
        wait_command_complete_flag();
        boot(1'b1, 8'hFF, 1'b0, 1'b1);
        wait_command_complete_flag();
        rd(4'hA, rv);
        chk("recovered", rv, 8'h06);
        wr(4'h2, 8'h06);
        wr(4'h3, 8'hFF);
        wr(4'hB, 8'h01);
        wait_command_complete_flag();
        chk("prog_ok", rv & 8'h20, 8'h00);
        boot(1'b0, 8'hFE, 1'b0, 1'b0);
        wait_command_complete_flag();
        rd(4'h7, rv);
        chk("sec_persist", rv, 8'hFE);
    endtask : t_recover
    task automatic print_verdict;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    initial begin
        #200000;
        fails++;
        print_verdict();
    end
    initial begin
        t_load_ok();
        t_load_dbl();
        t_special();
        t_cmd();
        t_abort();
        t_recover();
        print_verdict();
    end
endmodule : frsc_top_tb
`default_nettype wire
